// >>> design/tmb_timer.sv
`timescale 1ns/1ps
module tmb_timer
    import tmb_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [tmb_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tmb_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic primary_timer_pin_in,
    output logic primary_timer_pin_out,
    output logic primary_timer_pin_oe,
    input wire logic secondary_timer_pin_in,
    output logic secondary_timer_pin_out,
    output logic secondary_timer_pin_oe,
    output logic irq
);
    import tmb_pkg::*;

    logic [15:0] timer_control;
    logic [15:0] timer_count_value;
    logic [15:0] reload_compare_value;
    logic [IRQ_BITS-1:0] timer_irq_status;
    logic [IRQ_BITS-1:0] timer_irq_enable;
    logic aw_got, w_got;
    logic [5:0] aw_index;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_got, next_w_got, next_bvalid, next_rvalid;
    logic do_write, ctl_wr, value_wr, reload_wr, clear_wr, enable_wr;
    logic [5:0] ar_index;
    logic pri_prev, sec_prev, pri_fall, sec_fall;
    logic presc_tick, tick, count_down, roll_up, roll_down, roll;
    logic ext_cfg, ext_set, ext_toggle, ext_reload, capture;
    logic ovf_event, ext_event;
    logic [15:0] ctl_merged, value_merged;

    assign aw_index = s_axi_awaddr[7:2];
    assign ar_index = s_axi_araddr[7:2];

    // Write channel bookkeeping; address and data taken in any order
    always_comb begin
        do_write = aw_got && w_got && !s_axi_bvalid;
        next_aw_got = (aw_got || (s_axi_awvalid && s_axi_awready))
            && !do_write;
        next_w_got = (w_got || (s_axi_wvalid && s_axi_wready))
            && !do_write;
        next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
        next_rvalid = (s_axi_arvalid && s_axi_arready)
            || (s_axi_rvalid && !s_axi_rready);
    end

    // Each ready held low once its own half is taken or while a reply waits
    always_ff @(posedge clock) begin
        if (rst) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
        end else begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            s_axi_awready <= !next_aw_got && !next_bvalid;
            s_axi_wready <= !next_w_got && !next_bvalid;
            s_axi_bvalid <= next_bvalid;
        end
    end

    // Latched write payload
    logic [5:0] w_index;
    always_ff @(posedge clock) begin
        if (rst) begin
            w_index <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                w_index <= aw_index;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bresp <= (ctl_wr || value_wr || reload_wr
                    || clear_wr || enable_wr) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Write decode
    always_comb begin
        ctl_wr = do_write && (w_index == IDX_CONTROL);
        value_wr = do_write && (w_index == IDX_VALUE);
        reload_wr = do_write && (w_index == IDX_RELOAD);
        clear_wr = do_write && (w_index == IDX_IRQ_CLEAR);
        enable_wr = do_write && (w_index == IDX_IRQ_ENABLE);
        ctl_merged = merge_lanes(timer_control, w_data, w_strb);
        value_merged = merge_lanes(timer_count_value, w_data, w_strb);
    end

    // Read channel; one-cycle answer, unmapped gives SLVERR
    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rresp <= RESP_OKAY;
                unique case (ar_index)
                    IDX_CONTROL: s_axi_rdata <=
                        {16'h0000, timer_control & CTL_WRITE_MASK};
                    IDX_VALUE: s_axi_rdata <=
                        {16'h0000, timer_count_value};
                    IDX_RELOAD: s_axi_rdata <=
                        {16'h0000, reload_compare_value};
                    IDX_IRQ_STATUS: s_axi_rdata <=
                        {30'h0, timer_irq_status};
                    IDX_IRQ_ENABLE: s_axi_rdata <=
                        {30'h0, timer_irq_enable};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // Pin history; inputs are synchronous to clock
    always_ff @(posedge clock) begin
        if (rst) begin
            pri_prev <= 1'b0;
            sec_prev <= 1'b0;
        end else begin
            pri_prev <= primary_timer_pin_in;
            sec_prev <= secondary_timer_pin_in;
        end
    end

    tmb_prescaler i_tmb_prescaler (
        .clock(clock),
        .rst(rst),
        .prescale_select(timer_control[CTL_PRESCALE_LSB +: 3]),
        .tick(presc_tick)
    );

    // Count source, direction and external-event decode
    always_comb begin
        pri_fall = pri_prev && !primary_timer_pin_in
            && !timer_control[CTL_CLK_OUT];
        sec_fall = sec_prev && !secondary_timer_pin_in;
        tick = timer_control[CTL_RUN] && (timer_control[CTL_COUNTER_SEL]
            ? pri_fall : presc_tick);
        count_down = timer_control[CTL_COUNT_DOWN]
            && !secondary_timer_pin_in;
        roll_up = tick && !count_down
            && (timer_count_value == reload_compare_value);
        roll_down = tick && count_down
            && (timer_count_value == 16'h0000);
        roll = roll_up || roll_down;
        ext_cfg = (timer_control[CTL_CAPTURE_RELOAD]
                && timer_control[CTL_EXT_ENABLE])
            || (!timer_control[CTL_CAPTURE_RELOAD]
                && !timer_control[CTL_COUNT_DOWN]
                && timer_control[CTL_EXT_ENABLE])
            || (timer_control[CTL_SET_MODE:CTL_RESET_MODE] != 2'h0);
        ext_set = sec_fall && ext_cfg;
        ext_toggle = roll && !timer_control[CTL_CAPTURE_RELOAD]
            && timer_control[CTL_COUNT_DOWN]
            && (timer_control[CTL_SET_MODE:CTL_RESET_MODE] == 2'h0);
        capture = sec_fall && timer_control[CTL_CAPTURE_RELOAD]
            && timer_control[CTL_EXT_ENABLE];
        // Waveform output suppresses the edge-triggered reload
        ext_reload = sec_fall && timer_control[CTL_RUN]
            && !timer_control[CTL_CAPTURE_RELOAD]
            && timer_control[CTL_EXT_ENABLE]
            && (timer_control[CTL_SET_MODE:CTL_RESET_MODE] == 2'h0);
        ovf_event = roll && !timer_control[CTL_CLK_OUT];
        ext_event = ext_set
            || (ctl_wr && w_strb[0] && w_data[CTL_EXT_FLAG]);
    end

    // Control register; hardware sets win over a software clear
    always_ff @(posedge clock) begin
        if (rst) begin
            timer_control <= CTL_RESET;
        end else begin
            if (ctl_wr) begin
                timer_control <= ctl_merged & CTL_WRITE_MASK;
            end
            if (ext_set) begin
                timer_control[CTL_EXT_FLAG] <= 1'b1;
            end else if (ext_toggle && !ctl_wr) begin
                timer_control[CTL_EXT_FLAG] <=
                    !timer_control[CTL_EXT_FLAG];
            end
            if (roll) begin
                timer_control[CTL_OVF_FLAG] <= 1'b1;
            end
        end
    end

    // Counter; a software load overrides the step of that cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            timer_count_value <= VALUE_RESET;
        end else if (value_wr) begin
            timer_count_value <= value_merged;
        end else if (ext_reload || roll_up) begin
            timer_count_value <= 16'h0000;
        end else if (roll_down) begin
            timer_count_value <= reload_compare_value;
        end else if (tick) begin
            timer_count_value <= count_down
                ? timer_count_value - 16'h0001
                : timer_count_value + 16'h0001;
        end
    end

    // Reload/compare register, also the capture target
    always_ff @(posedge clock) begin
        if (rst) begin
            reload_compare_value <= RELOAD_RESET;
        end else if (capture) begin
            reload_compare_value <= timer_count_value;
        end else if (reload_wr) begin
            reload_compare_value <=
                merge_lanes(reload_compare_value, w_data, w_strb);
        end
    end

    // Sticky status; set wins over the write-one clear
    always_ff @(posedge clock) begin
        if (rst) begin
            timer_irq_status <= '0;
            timer_irq_enable <= '0;
            irq <= 1'b0;
        end else begin
            timer_irq_status <= (timer_irq_status
                & ~((clear_wr && w_strb[0]) ? w_data[IRQ_BITS-1:0]
                    : {IRQ_BITS{1'b0}}))
                | ({IRQ_BITS{timer_control[CTL_INT_ENABLE]}}
                    & {ext_event && !ext_toggle, ovf_event});
            if (enable_wr && w_strb[0]) begin
                timer_irq_enable <= w_data[IRQ_BITS-1:0];
            end
            irq <= |(timer_irq_status & timer_irq_enable);
        end
    end

    // Pin drivers: clock output on primary, waveform on secondary
    always_ff @(posedge clock) begin
        if (rst) begin
            primary_timer_pin_out <= 1'b0;
            primary_timer_pin_oe <= 1'b0;
            secondary_timer_pin_out <= 1'b0;
            secondary_timer_pin_oe <= 1'b0;
        end else begin
            primary_timer_pin_oe <= timer_control[CTL_CLK_OUT]
                && !timer_control[CTL_COUNTER_SEL];
            if (!timer_control[CTL_CLK_OUT]) begin
                primary_timer_pin_out <= 1'b0;
            end else if (roll) begin
                primary_timer_pin_out <= !primary_timer_pin_out;
            end
            secondary_timer_pin_oe <=
                timer_control[CTL_SET_MODE:CTL_RESET_MODE] != 2'h0;
            if (ctl_wr) begin
                secondary_timer_pin_out <= ctl_merged[CTL_SET_MODE];
            end else if (roll) begin
                secondary_timer_pin_out <= !secondary_timer_pin_out;
            end
        end
    end

    property p_clkout_no_irq;
        @(posedge clock) disable iff (rst)
        $rose(timer_irq_status[IRQ_OVERFLOW])
            |-> !$past(timer_control[CTL_CLK_OUT]);
    endproperty
    a_clkout_no_irq: assert property (p_clkout_no_irq)
        else $error("overflow interrupt raised in clock output mode");

    property p_ext_edge_set;
        @(posedge clock) disable iff (rst)
        ext_cfg && sec_prev && !secondary_timer_pin_in
            |=> timer_control[CTL_EXT_FLAG];
    endproperty
    a_ext_edge_set: assert property (p_ext_edge_set)
        else $error("falling edge did not set trigger flag");

    property p_ext_set_stopped;
        @(posedge clock) disable iff (rst)
        !timer_control[CTL_RUN] && ext_cfg && sec_fall
            |=> timer_control[CTL_EXT_FLAG];
    endproperty
    a_ext_set_stopped: assert property (p_ext_set_stopped)
        else $error("trigger flag missed while stopped");

    property p_ext_toggle;
        @(posedge clock) disable iff (rst)
        ext_toggle && !ext_set && !ctl_wr
            |=> timer_control[CTL_EXT_FLAG]
                != $past(timer_control[CTL_EXT_FLAG]);
    endproperty
    a_ext_toggle: assert property (p_ext_toggle)
        else $error("trigger flag did not toggle on rollover");

    property p_irq_follows;
        @(posedge clock) disable iff (rst)
        (timer_irq_status & timer_irq_enable) != '0 |=> irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt not raised for enabled status");

    property p_ovf_set;
        @(posedge clock) disable iff (rst)
        roll_up || roll_down |=> timer_control[CTL_OVF_FLAG];
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow flag not set on rollover");

    property p_reserved_zero;
        @(posedge clock) disable iff (rst)
        s_axi_arvalid && s_axi_arready && ar_index == IDX_CONTROL
            |=> s_axi_rvalid && s_axi_rdata[14:13] == 2'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bits read nonzero");

    property p_stop_holds;
        @(posedge clock) disable iff (rst)
        !timer_control[CTL_RUN] && !value_wr
            |=> $stable(timer_count_value);
    endproperty
    a_stop_holds: assert property (p_stop_holds)
        else $error("count moved while stopped");

    property p_value_load;
        @(posedge clock) disable iff (rst)
        value_wr && w_strb[1:0] == 2'h3
            |=> timer_count_value == $past(w_data[15:0]);
    endproperty
    a_value_load: assert property (p_value_load)
        else $error("value write not applied next cycle");
endmodule // tmb_timer

// >>> design/tmb_pkg.sv
package tmb_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CONTROL = 6'h0a;
    localparam logic [5:0] IDX_VALUE = 6'h0b;
    localparam logic [5:0] IDX_RELOAD = 6'h0c;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h10;
    localparam logic [5:0] IDX_IRQ_CLEAR = 6'h11;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h12;
    localparam int ADDR_W = 8;

    // timer_control field positions
    localparam int CTL_CAPTURE_RELOAD = 0;
    localparam int CTL_INT_ENABLE = 1;
    localparam int CTL_RUN = 2;
    localparam int CTL_EXT_ENABLE = 3;
    localparam int CTL_COUNT_DOWN = 4;
    localparam int CTL_CLK_OUT = 5;
    localparam int CTL_EXT_FLAG = 6;
    localparam int CTL_OVF_FLAG = 7;
    localparam int CTL_PRESCALE_LSB = 8;
    localparam int CTL_RESET_MODE = 11;
    localparam int CTL_SET_MODE = 12;
    localparam int CTL_COUNTER_SEL = 15;
    // Bits 14:13 are reserved and never stored
    localparam logic [15:0] CTL_WRITE_MASK = 16'h9fff;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;

    // Interrupt status bits
    localparam int IRQ_OVERFLOW = 0;
    localparam int IRQ_EXTERNAL = 1;
    localparam int IRQ_BITS = 2;

    // Prescaler counter width covers the largest divide of 1024
    localparam int PRESCALE_W = 10;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Mask of prescaler bits that must all be one for a tick
    function automatic logic [PRESCALE_W-1:0] prescale_mask(
        input logic [2:0] sel
    );
        unique case (sel)
            3'h1: prescale_mask = 10'h003;
            3'h2: prescale_mask = 10'h00f;
            3'h3: prescale_mask = 10'h03f;
            3'h4: prescale_mask = 10'h0ff;
            3'h5: prescale_mask = 10'h3ff;
            default: prescale_mask = 10'h000;
        endcase
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge_lanes(
        input logic [15:0] old_value,
        input logic [31:0] new_value,
        input logic [3:0] strobe
    );
        merge_lanes[7:0] = strobe[0] ? new_value[7:0] : old_value[7:0];
        merge_lanes[15:8] = strobe[1] ? new_value[15:8] : old_value[15:8];
    endfunction
endpackage

// >>> design/tmb_prescaler.sv
`timescale 1ns/1ps
module tmb_prescaler
    import tmb_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] prescale_select,
    output logic tick
);
    import tmb_pkg::*;

    logic [PRESCALE_W-1:0] div_count;

    // Free-running divider; changing the select while running gives
    // an irregular first period, which software is told to avoid
    always_ff @(posedge clock) begin
        if (rst) begin
            div_count <= '0;
        end else begin
            div_count <= div_count + 10'h001;
        end
    end

    // One-cycle tick when the selected low bits are all ones
    always_ff @(posedge clock) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= (div_count & prescale_mask(prescale_select))
                == prescale_mask(prescale_select);
        end
    end
endmodule // tmb_prescaler

// >>> tb/tmb_pin_model.sv
`timescale 1ns/1ps
// Far side of both timer pins: drives a level unless the timer drives
module tmb_pin_model (
    input wire logic prim_level,
    input wire logic sec_level,
    input wire logic primary_timer_pin_out,
    input wire logic primary_timer_pin_oe,
    input wire logic secondary_timer_pin_out,
    input wire logic secondary_timer_pin_oe,
    output logic primary_timer_pin_in,
    output logic secondary_timer_pin_in
);
    // Wire level; the timer's own drive is fed back to its input
    assign primary_timer_pin_in = primary_timer_pin_oe ?
        primary_timer_pin_out : prim_level;
    assign secondary_timer_pin_in = secondary_timer_pin_oe ?
        secondary_timer_pin_out : sec_level;
endmodule // tmb_pin_model

// >>> tb/tb_timer_b_control_and_count.sv
`timescale 1ns/1ps
module tb_timer_b_control_and_count;
    import tmb_pkg::*;
    logic clock, rst, awv, wv, arv, bready, rready, prim_lvl, sec_lvl;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [15:0] cv;
    logic [1:0] bresp, rresp, resp_seen;
    logic awr, wr_rdy, bvalid, arr, rvalid, irq;
    logic p_in, p_out, p_oe, s_in, s_out, s_oe;
    int mismatches, cmp_count, cycles, div;
    tmb_timer i_tmb_timer (.clock(clock), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
        .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .primary_timer_pin_in(p_in), .primary_timer_pin_out(p_out),
        .primary_timer_pin_oe(p_oe), .secondary_timer_pin_in(s_in),
        .secondary_timer_pin_out(s_out), .secondary_timer_pin_oe(s_oe),
        .irq(irq));
    tmb_pin_model i_tmb_pin_model (.prim_level(prim_lvl),
        .sec_level(sec_lvl), .primary_timer_pin_out(p_out),
        .primary_timer_pin_oe(p_oe), .secondary_timer_pin_out(s_out),
        .secondary_timer_pin_oe(s_oe), .primary_timer_pin_in(p_in),
        .secondary_timer_pin_in(s_in));
    // 100 MHz clock
    always #5 clock = ~clock;
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard, well above the prescaler sweep
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            end_sim();
        end
    end
    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask
    // Address and data offered together, each dropped once taken
    // Waits for the answer; only the hang guard ends a stuck wait
    task automatic wr(input logic [5:0] idx, input logic [15:0] v);
        awaddr <= {idx, 2'h0};
        wdata <= {16'h0000, v};
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clock);
            if (awr && awv) awv <= 1'b0;
            if (wr_rdy && wv) wv <= 1'b0;
        end while (!bvalid);
        resp_seen = bresp;
    endtask
    task automatic rd(input logic [5:0] idx, output logic [31:0] v);
        araddr <= {idx, 2'h0};
        arv <= 1'b1;
        do begin
            @(posedge clock);
            if (arr && arv) arv <= 1'b0;
        end while (!rvalid);
        v = rdata;
        resp_seen = rresp;
    endtask
    task automatic rc(input logic [5:0] idx, input logic [31:0] e,
                      input string s);
        rd(idx, d);
        chk(s, e, d);
    endtask
    // Irq is registered once more after status or enable changes
    task automatic irq_is(input logic e);
        @(posedge clock);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    // Falling edges on a pin, three cycles low and high
    task automatic pulse(input bit sec, input int n);
        for (int i = 0; i < n; i++) begin
            if (sec) sec_lvl <= 1'b0; else prim_lvl <= 1'b0;
            repeat (3) @(posedge clock);
            if (sec) sec_lvl <= 1'b1; else prim_lvl <= 1'b1;
            repeat (3) @(posedge clock);
        end
    endtask
    initial begin
        clock = 0; rst = 1; awv = 0; wv = 0; arv = 0; bready = 1;
        rready = 1; prim_lvl = 1; sec_lvl = 1; awaddr = 0; araddr = 0;
        wdata = 0; wstrb = 4'h3; mismatches = 0; cmp_count = 0;
        cycles = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // Reset values, unmapped access
        rc(IDX_CONTROL, 32'h0, "control reset");
        rc(IDX_VALUE, 32'h0, "value reset");
        rc(6'h3f, 32'h0, "unmapped rdata");
        chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, resp_seen});
        wr(6'h3f, 16'hffff);
        chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp_seen});
        wr(IDX_CONTROL, 16'h6000);
        rc(IDX_CONTROL, 32'h0, "reserved bits");
        wr(IDX_VALUE, 16'ha5c3);
        chk("bresp ok", {30'h0, RESP_OKAY}, {30'h0, resp_seen});
        rc(IDX_VALUE, 32'ha5c3, "value rw");
        chk("rresp ok", {30'h0, RESP_OKAY}, {30'h0, resp_seen});
        // Every output mode code
        for (int m = 0; m < 4; m++) begin
            wr(IDX_CONTROL, 16'(m << 11));
            @(posedge clock);
            chk("sec oe", 32'(m != 0), {31'h0, s_oe});
            chk("sec out", 32'(m >> 1), {31'h0, s_out});
        end
        // Event counting on the primary pin, stop, wrap
        wr(IDX_RELOAD, 16'h0007);
        wr(IDX_VALUE, 16'h0000);
        wr(IDX_IRQ_ENABLE, 16'h0001);
        wr(IDX_CONTROL, 16'h8006);
        pulse(0, 5);
        rc(IDX_VALUE, 32'h5, "edge count");
        wr(IDX_CONTROL, 16'h8002);
        pulse(0, 2);
        rc(IDX_VALUE, 32'h5, "held count");
        wr(IDX_CONTROL, 16'h8006);
        pulse(0, 3);
        rc(IDX_VALUE, 32'h0, "wrap");
        rc(IDX_CONTROL, 32'h8086, "overflow flag");
        rc(IDX_IRQ_STATUS, 32'h1, "status");
        irq_is(1'b1);
        wr(IDX_IRQ_ENABLE, 16'h0000);
        irq_is(1'b0);
        wr(IDX_IRQ_ENABLE, 16'h0001);
        irq_is(1'b1);
        wr(IDX_IRQ_CLEAR, 16'h0001);
        irq_is(1'b0);
        // Down count with low direction pin, toggling trigger flag
        sec_lvl <= 1'b0;
        wr(IDX_VALUE, 16'h0002);
        wr(IDX_CONTROL, 16'h8014);
        pulse(0, 3);
        rc(IDX_VALUE, 32'h7, "down reload");
        rc(IDX_CONTROL, 32'h80d4, "down flags");
        sec_lvl <= 1'b1;
        // Trigger flag while stopped; capture copies the count
        wr(IDX_VALUE, 16'h0055);
        // Capture+enable, reload+enable (both stopped), then no config
        for (int k = 0; k < 3; k++) begin
            cv = (k == 0) ? 16'h0009 : ((k == 1) ? 16'h0008 : 16'h0002);
            wr(IDX_CONTROL, cv);
            pulse(1, 1);
            rc(IDX_CONTROL, {16'h0, cv | ((k < 2) ? 16'h0040 : 16'h0000)},
               "trigger flag");
        end
        rc(IDX_RELOAD, 32'h55, "capture");
        // Writing the flag forces an interrupt
        wr(IDX_IRQ_ENABLE, 16'h0002);
        wr(IDX_CONTROL, 16'h0042);
        irq_is(1'b1);
        rc(IDX_IRQ_STATUS, 32'h2, "forced status");
        wr(IDX_IRQ_CLEAR, 16'h0003);
        irq_is(1'b0);
        // Clock output: flag still set, no interrupt event
        wr(IDX_RELOAD, 16'h0003);
        wr(IDX_IRQ_ENABLE, 16'h0001);
        wr(IDX_VALUE, 16'h0000);
        wr(IDX_CONTROL, 16'h0026);
        repeat (40) @(posedge clock);
        chk("prim oe", 32'h1, {31'h0, p_oe});
        // Rollover every four clocks, so the output flips in four
        d = {31'h0, p_out};
        repeat (4) @(posedge clock);
        chk("prim out", {31'h0, ~d[0]}, {31'h0, p_out});
        rc(IDX_IRQ_STATUS, 32'h0, "clkout status");
        rd(IDX_CONTROL, d);
        chk("clkout flag", 32'h1, {31'h0, d[7]});
        // Mid-run reset clears a loaded count and the control word
        wr(IDX_VALUE, 16'h1234);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rc(IDX_VALUE, 32'h0, "value after reset");
        rc(IDX_CONTROL, 32'h0, "control after reset");
        // Prescaler sweep, 32 ticks each, setting changed when stopped
        wr(IDX_RELOAD, 16'hffff);
        for (int p = 0; p < 8; p++) begin
            div = (p > 5) ? 1 : (1 << (2 * p));
            wr(IDX_CONTROL, 16'(p << 8));
            wr(IDX_VALUE, 16'h0000);
            wr(IDX_CONTROL, 16'(p << 8) | 16'h0004);
            repeat (32 * div) @(posedge clock);
            wr(IDX_CONTROL, 16'h0000);
            rd(IDX_VALUE, d);
            chk("prescale", 32'h1,
                32'(d >= 31 && d <= 33 + 6 / div));
        end
        end_sim();
    end
endmodule // tb_timer_b_control_and_count
